// [src/aimx_pkg.sv]
package aimx_pkg;
  // Register map, byte offsets
  localparam logic [3:0] SELECT_OFFSET  = 4'h0;
  localparam logic [3:0] CONTROL_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET  = 4'h8;
  // Selection field layout
  localparam int POS_CODE_LSB = 4;
  localparam int NEG_CODE_LSB = 0;
  localparam int CODE_W       = 4;
  localparam int SRC_W        = 16;
  // Reset values
  localparam logic [7:0] SELECT_RESET  = 8'h01;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  // Control bits
  localparam int CTRL_SEQ_BIT  = 0;
  localparam int CTRL_BIAS_BIT = 1;
  // Source codes
  localparam logic [3:0] CODE_CH7      = 4'h7;
  localparam logic [3:0] CODE_GROUND   = 4'h8;
  localparam logic [3:0] CODE_SUPPLY   = 4'h9;
  localparam logic [3:0] CODE_RESERVED = 4'ha;
  localparam logic [3:0] CODE_REF_POS  = 4'hb;
  localparam logic [3:0] CODE_REF_NEG  = 4'hc;
  localparam logic [3:0] CODE_DIODE_P  = 4'hd;
  localparam logic [3:0] CODE_DIODE_M  = 4'he;
  localparam logic [3:0] CODE_COMMON   = 4'hf;
  localparam logic [7:0] TEMP_PAIR     = 8'hde;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : aimx_pkg

// [src/aimx_decode.sv]
`timescale 1ns/1ns
// One half of the dual selector: code to one-hot switch enables
module aimx_decode (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_sync_n,
  // Code in
  input  wire logic [3:0]  code,
  // Switch enables out, registered
  output logic      [15:0] switch_en
);
  logic [15:0] next_switch_en;

  // Reserved code opens every switch; shifting a one keeps 0..7 ascending
  always_comb
  begin
    next_switch_en = 16'h0001 << code;
    if (code == aimx_pkg::CODE_RESERVED)
      next_switch_en = 16'h0000;
  end

  // Registered so the analog switches never see decode glitches
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      switch_en <= 16'h0002;
    else
      switch_en <= next_switch_en;
  end
endmodule : aimx_decode

// [src/aimx_select.sv]
`timescale 1ns/1ns
// Functional notes
// - Upper nibble picks non-inverting input source
// - Lower nibble picks inverting input source
// - Codes 0..7 select channels zero..seven
// - Codes select ground, supply, reference pins
// - Code 1111 selects internal common mode
// - Halves decode independently, same options
// - Sequence mode overrides register selection
// - Value 0xde places diode pair
// - Diodes selected: burnout off, diode bias on
module aimx_select (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Sequencer, same clock domain
  input  wire logic [7:0]  seq_select,
  // Analog switch controls
  output logic      [15:0] pos_switch_en,
  output logic      [15:0] neg_switch_en,
  output logic             burnout_enable,
  output logic             diode_bias_enable
);
  logic       rst_meta_n;
  logic       rst_sync_n;
  logic [7:0] input_source_select;
  logic [1:0] control;
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] active_select;
  logic       temp_selected;
  logic       do_write;

  // Reset released through two flops, asserted at once
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Channels ready while nothing of that kind is held and no write response is pending
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // Address and data may arrive in either order
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries bits
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      input_source_select <= aimx_pkg::SELECT_RESET;
      control             <= aimx_pkg::CONTROL_RESET;
    end
    else if (do_write && w_strb[0])
    begin
      if (aw_addr == aimx_pkg::SELECT_OFFSET)
        input_source_select <= w_data[7:0];
      else if (aw_addr == aimx_pkg::CONTROL_OFFSET)
        control <= w_data[1:0];
    end
  end

  // Write response; unmapped address gets SLVERR
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= aimx_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == aimx_pkg::SELECT_OFFSET ||
          aw_addr == aimx_pkg::CONTROL_OFFSET)
        s_axi_bresp <= aimx_pkg::RESP_OKAY;
      else
        s_axi_bresp <= aimx_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read channel; one outstanding read, answer next cycle
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= aimx_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= aimx_pkg::RESP_OKAY;
      case (s_axi_araddr)
        aimx_pkg::SELECT_OFFSET:
          s_axi_rdata <= {24'h000000, input_source_select};
        aimx_pkg::CONTROL_OFFSET:
          s_axi_rdata <= {30'h0, control};
        aimx_pkg::STATUS_OFFSET:
          s_axi_rdata <= {22'h0, diode_bias_enable, burnout_enable,
                          active_select};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= aimx_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Sequencer code replaces the register while sequencing
  assign active_select = control[aimx_pkg::CTRL_SEQ_BIT] ?
                         seq_select : input_source_select;

  // Either diode code on either half counts as the sensor selected
  assign temp_selected =
    active_select[7:4] == aimx_pkg::CODE_DIODE_P ||
    active_select[7:4] == aimx_pkg::CODE_DIODE_M ||
    active_select[3:0] == aimx_pkg::CODE_DIODE_P ||
    active_select[3:0] == aimx_pkg::CODE_DIODE_M;

  // Burnout gated, its config bit left untouched
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      burnout_enable    <= 1'b0;
      diode_bias_enable <= 1'b0;
    end
    else
    begin
      burnout_enable    <= control[aimx_pkg::CTRL_BIAS_BIT] &&
                           !temp_selected;
      diode_bias_enable <= temp_selected;
    end
  end

  // Two identical decoders, one per converter input
  aimx_decode u_pos (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .code       (active_select[7:4]),
    .switch_en  (pos_switch_en)
  );

  aimx_decode u_neg (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .code       (active_select[3:0]),
    .switch_en  (neg_switch_en)
  );
endmodule : aimx_select

// [sim/aimx_select_monitor.sv]
`timescale 1ns/1ns
// Protocol and switch checks at the selector ports
module aimx_select_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Switch side
  input wire logic [15:0] pos_switch_en,
  input wire logic [15:0] neg_switch_en,
  input wire logic        burnout_enable,
  input wire logic        diode_bias_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Two closed switches would short two sources together
  AST_POS_ONEHOT: assert property ($onehot0(pos_switch_en))
    else $error("pos switches not one-hot");
  AST_NEG_ONEHOT: assert property ($onehot0(neg_switch_en))
    else $error("neg switches not one-hot");
  AST_BIAS_EXCL: assert property (diode_bias_enable |-> !burnout_enable)
    else $error("burnout on with diode bias");
  // Bus answers and refusals
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (diode_bias_enable);
endmodule : aimx_select_monitor

bind aimx_select aimx_select_monitor u_mon (.*);

// [sim/aimx_switch_model.sv]
`timescale 1ns/1ns
// Analog switch bank: reports which source is closed on each input
module aimx_switch_model (
  // Switch enables
  input wire logic [15:0] pos_switch_en,
  input wire logic [15:0] neg_switch_en,
  // Closed source, 4'ha when open or shorted
  output logic     [3:0]  pos_src,
  output logic     [3:0]  neg_src
);
  // Two closed switches are not a valid source, so report open
  function automatic logic [3:0] aimx_enc(input logic [15:0] v);
    logic [3:0] r = 4'ha;
    for (int i = 0; i < 16; i++)
      if (v === (16'h0001 << i))
        r = i[3:0];
    return r;
  endfunction : aimx_enc
  assign pos_src = aimx_enc(pos_switch_en);
  assign neg_src = aimx_enc(neg_switch_en);
endmodule : aimx_switch_model

// [sim/testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        burnout_enable, diode_bias_enable;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [7:0]  seq_select = 8'h00;
  logic [15:0] pos_switch_en, neg_switch_en;
  logic [3:0]  pos_src, neg_src;
  int          err_total = 0, check_count = 0, cyc = 0;
  // 100 ns clock
  always #50 clk_sys = ~clk_sys;
  aimx_select u_dut (.*);
  aimx_switch_model u_sw (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_sw(input logic [7:0] e);
    chk({24'h0, pos_src, neg_src}, {24'h0, e});
  endtask : chk_sw
  // Offer address and data together, hold each until taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rdr
  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask : settle
  task automatic t_codes();
    rdr(aimx_pkg::SELECT_OFFSET);
    chk(rd, 32'h01);
    chk_sw(8'h01);
    // Code 1010 is never written
    for (int c = 0; c < 16; c++)
      if (c != 10) // full-channel part, all pins bonded
      begin
        wr(aimx_pkg::SELECT_OFFSET, {24'h0, c[3:0], c[3:0]}, 4'hf);
        settle();
        chk_sw({c[3:0], c[3:0]});
      end
    wr(aimx_pkg::SELECT_OFFSET, 32'h3c, 4'hf);
    settle();
    chk_sw(8'h3c);
  endtask : t_codes
  // Diode pair suppresses burnout but keeps its setting
  task automatic t_temp();
    wr(aimx_pkg::CONTROL_OFFSET, 32'h2, 4'hf);
    settle();
    chk({30'h0, diode_bias_enable, burnout_enable}, 32'h1);
    wr(aimx_pkg::SELECT_OFFSET, 32'hde, 4'hf);
    settle();
    chk_sw(8'hde);
    chk({30'h0, diode_bias_enable, burnout_enable}, 32'h2);
    rdr(aimx_pkg::CONTROL_OFFSET);
    chk(rd, 32'h2);
  endtask : t_temp
  task automatic t_seq();
    seq_select <= 8'h47;
    wr(aimx_pkg::CONTROL_OFFSET, 32'h1, 4'hf);
    settle();
    chk_sw(8'h47);
    seq_select <= 8'hb0;
    settle();
    chk_sw(8'hb0);
    wr(aimx_pkg::CONTROL_OFFSET, 32'h0, 4'hf);
    settle();
    chk_sw(8'hde);
  endtask : t_seq
  // Unmapped place and empty strobe leave the selection alone
  task automatic t_bus();
    wr(4'hc, 32'h55, 4'hf);
    chk({30'h0, rs}, {30'h0, aimx_pkg::RESP_SLVERR});
    wr(aimx_pkg::SELECT_OFFSET, 32'h23, 4'h0);
    chk({30'h0, rs}, {30'h0, aimx_pkg::RESP_OKAY});
    rdr(4'hc);
    chk({30'h0, rs}, {30'h0, aimx_pkg::RESP_SLVERR});
    rdr(aimx_pkg::STATUS_OFFSET);
    chk(rd, 32'h2de);
  endtask : t_bus
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_codes();
    t_temp();
    t_seq();
    t_bus();
    wrap_up();
  end
endmodule : testbench
